// *** hdl/fld_limit_defs.vh ***
// constants shared by the four-level limit detector and its limit channel
// assumes a 100 MHz system clock and a 16-bit level scale where all ones is 100 %
`ifndef FLD_LIMIT_DEFS_VH
`define FLD_LIMIT_DEFS_VH

// ==========================================================
// clock and timing
`define FLD_CLK_KHZ         100000
`define FLD_MS_CYCLES       (`FLD_CLK_KHZ)
`define FLD_TEACH_TIME_MS   5000
`define FLD_TEACH_CYCLES    (`FLD_TEACH_TIME_MS * `FLD_MS_CYCLES)
`define FLD_HOLD_MAX_MS     9'h1F4

// ==========================================================
// sensitivity, in tenths: 0 is off, 1 is the lowest computed threshold
`define FLD_SENS_MAX        9'h18F
`define FLD_SENS_DEFAULT    9'h01E
`define FLD_SENS_SCALE      9'h00A
`define FLD_CLAMP_PCT       97
`define FLD_FULL_SCALE      16'hFFFF

// ==========================================================
// limit indices and hardware compare outputs (output numbers count from 1)
`define FLD_LIM_GAP         0
`define FLD_LIM_ONE         1
`define FLD_LIM_TWO         2
`define FLD_LIM_CRASH       3
`define FLD_HW_MIN_REV      8'h04
`define FLD_OUT_GAP_S1      5'h04
`define FLD_OUT_GAP_S2      5'h05
`define FLD_OUT_CRASH       5'h06

`endif

// *** hdl/fld_limit_channel.v ***
// one limit: strict comparator, minimum hold timer and latch-on-zero-hold
// assumes level, threshold and hold time come from logic on the same clock
`default_nettype none
`include "fld_limit_defs.vh"

module fld_limit_channel #(
  parameter MS_CYCLES = `FLD_MS_CYCLES      // clock cycles per millisecond
) (
  input  wire        clk,                   // system clock
  input  wire        rst,                   // asynchronous reset, active high
  input  wire        enable,                // process cycle running
  input  wire        sample_tick,           // one pulse per measurement sample
  input  wire        disabled,              // limit switched off
  input  wire [15:0] level,                 // conditioned signal level
  input  wire [15:0] thr,                   // threshold in use
  input  wire [8:0]  hold_ms,               // hold time in ms, already clamped
  output reg         active                 // switching state of this limit
);

  localparam PW = $clog2(MS_CYCLES);
  localparam integer  MS_LAST_I = MS_CYCLES - 1;
  localparam [PW-1:0] MS_LAST   = MS_LAST_I[PW-1:0];

  reg  [PW-1:0] pre;
  reg  [8:0]    held_ms;
  wire          above     = sample_tick & ~disabled & (level > thr);
  wire          below     = sample_tick & ~(~disabled & (level > thr));
  wire          hold_done = (held_ms >= hold_ms);

  // ==========================================================
  // hold timer restarts at every fresh assertion, so the hold is measured from it
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      active  <= 1'b0;
      pre     <= {PW{1'b0}};
      held_ms <= 9'h000;
    end else if (!enable) begin
      active  <= 1'b0;
      pre     <= {PW{1'b0}};
      held_ms <= 9'h000;
    end else if (!active) begin
      if (above) begin
        active  <= 1'b1;
        pre     <= {PW{1'b0}};
        held_ms <= 9'h000;
      end
    end else if (!hold_done) begin
      if (pre == MS_LAST) begin
        pre     <= {PW{1'b0}};
        held_ms <= held_ms + 9'h001;
      end else begin
        pre <= pre + 1'b1;
      end
    end else if (hold_ms != 9'h000 && below) begin
      active <= 1'b0;
    end
    // zero hold never reaches the release branch, so the output latches
  end

endmodule // fld_limit_channel

`default_nettype wire

// *** hdl/fld_limit_detector.v ***
// four-level limit detector: gap, limit 1, limit 2 and crash against one level
// assumes run and teach come from machine pins; all other inputs share clk
`default_nettype none
`include "fld_limit_defs.vh"

module fld_limit_detector #(
  parameter NUM_OUTS     = 8,                   // outputs in the channel, numbered from 1
  parameter MS_CYCLES    = `FLD_MS_CYCLES,      // clock cycles per millisecond
  parameter TEACH_CYCLES = `FLD_TEACH_CYCLES    // clock cycles of one teach interval
) (
  input  wire                clk,                 // system clock, 100 MHz
  input  wire                rst,                 // asynchronous reset, active high
  input  wire                cycle_run_pin,       // cycle start/stop level from the control
  input  wire                teach_pin,           // teach request level from the control
  input  wire                sample_tick,         // one pulse per new measurement sample
  input  wire [15:0]         meas_sample,         // measurement, two's complement
  input  wire [15:0]         signal_offset,       // offset subtracted from the measurement unless sensor_is_ae
  input  wire                abs_mode,            // 1 absolute, 0 positive-only unless sensor_is_ae forces absolute
  input  wire                sensor_is_ae,        // acoustic emission sensor selected
  input  wire                sensor_sel,          // 0 sensor 1, 1 sensor 2
  input  wire                hw_compare_sel,      // hardware compare setting
  input  wire [7:0]          fpga_rev,            // programmable logic revision
  input  wire [3:0]          first_output_select, // first software output, 0 is off
  input  wire [35:0]         sens_tenths,         // four sensitivities in tenths, gap lowest
  input  wire [63:0]         manual_thr,          // four manual thresholds, full scale 100 %
  input  wire [35:0]         hold_ms,             // four hold times in ms
  output reg  [NUM_OUTS-1:0] switch_out,          // switching outputs, bit 0 is output 1
  output wire [3:0]          limit_active,        // raw state of the four limits
  output reg                 infeed_enable,       // infeed release to the control
  output wire                teach_busy,          // teach interval running
  output reg  [15:0]         teach_peak_level,    // stored teach peak
  output reg  [63:0]         thr_shown,           // four thresholds for display
  output wire                hw_compare_on        // hardware compare mode in force
);

  // ==========================================================
  // constants and state codes
  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_TEACH = 3'b010;
  localparam [2:0] ST_RUN   = 3'b100;

  localparam TW = $clog2(TEACH_CYCLES);
  localparam integer  TEACH_LAST_I = TEACH_CYCLES - 1;
  localparam [TW-1:0] TEACH_LAST   = TEACH_LAST_I[TW-1:0];
  localparam [31:0] CLAMP_W = (65535 * `FLD_CLAMP_PCT) / 100;
  localparam [15:0] CLAMP_LVL = CLAMP_W[15:0];

  // ==========================================================
  // functions
  // threshold = peak * (10 + s) / 10: s = 1 gives 1.1 x peak, growing with s
  function [15:0] calc_thr;
    input [15:0] pk;
    input [8:0]  s;
    reg   [24:0] prod;
    reg   [24:0] quo;
    begin
      prod = {9'h000, pk} * {16'h0000, s + `FLD_SENS_SCALE};
      quo  = prod / {16'h0000, `FLD_SENS_SCALE};
      if (quo > {9'h000, CLAMP_LVL}) begin
        calc_thr = CLAMP_LVL;
      end else begin
        calc_thr = quo[15:0];
      end
    end
  endfunction

  // output number that a limit drives, 0 for none
  function [4:0] slot_of;
    input [1:0] limit_strategy;
    input [3:0] fos;
    input       hw;
    input       s2;
    begin
      slot_of = 5'h00;
      if (hw && limit_strategy == `FLD_LIM_GAP) begin
        slot_of = s2 ? `FLD_OUT_GAP_S2 : `FLD_OUT_GAP_S1;
      end else if (hw && limit_strategy == `FLD_LIM_CRASH) begin
        slot_of = `FLD_OUT_CRASH;
      end else if (fos != 4'h0) begin
        if (hw) begin
          slot_of = {1'b0, fos} + {3'b000, limit_strategy} - 5'h01;
        end else begin
          slot_of = {1'b0, fos} + {3'b000, limit_strategy};
        end
      end
      // fos off leaves software slots at none
    end
  endfunction

  // ==========================================================
  // pin synchronisers
  reg run_meta;
  reg run_s;
  reg teach_meta;
  reg teach_s;
  reg run_d;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      run_meta   <= 1'b0;
      run_s      <= 1'b0;
      teach_meta <= 1'b0;
      teach_s    <= 1'b0;
      run_d      <= 1'b0;
    end else begin
      run_meta   <= cycle_run_pin;
      run_s      <= run_meta;
      teach_meta <= teach_pin;
      teach_s    <= teach_meta;
      run_d      <= run_s;
    end
  end

  wire run_rise = run_s & ~run_d;

  // ==========================================================
  // signal conditioning
  // measurement and offset both sign-extended; 17 bits cannot overflow
  wire        force_abs = abs_mode | sensor_is_ae;
  wire [16:0] offs      = sensor_is_ae ? 17'h00000 : {signal_offset[15], signal_offset};
  wire [16:0] diff      = {meas_sample[15], meas_sample} - offs;
  wire [16:0] neg       = 17'h00000 - diff;
  reg  [15:0] level;

  always @* begin
    if (!diff[16]) begin
      level = diff[15:0];
    end else if (force_abs) begin
      level = neg[15:0];
    end else begin
      level = 16'h0000;
    end
  end

  // ==========================================================
  // cycle and teach sequencing
  reg  [2:0]    state;
  reg  [TW-1:0] teach_cnt;
  reg  [15:0]   teach_max;
  wire          teach_done = (state == ST_TEACH) & run_s & (teach_cnt == TEACH_LAST);
  wire [15:0]   next_teach_max = (sample_tick && level > teach_max) ? level : teach_max;
  // thresholds load at a plain start and at teach completion only
  wire          load_thr = ((state == ST_IDLE) & run_rise & ~teach_s) | teach_done;
  wire [15:0]   load_pk  = (state == ST_TEACH) ? next_teach_max : teach_peak_level;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state            <= ST_IDLE;
      infeed_enable    <= 1'b0;
      teach_cnt        <= {TW{1'b0}};
      teach_max        <= 16'h0000;
      teach_peak_level <= 16'h0000;
    end else begin
      case (state)
        ST_IDLE: begin
          infeed_enable <= 1'b0;
          if (run_rise && teach_s) begin
            state     <= ST_TEACH;
            teach_cnt <= {TW{1'b0}};
            teach_max <= 16'h0000;
          end else if (run_rise) begin
            state         <= ST_RUN;
            infeed_enable <= 1'b1;
          end
        end
        ST_TEACH: begin
          if (!run_s) begin
            state <= ST_IDLE;
          end else if (teach_done) begin
            state            <= ST_RUN;
            infeed_enable    <= 1'b1;
            teach_peak_level <= next_teach_max;
          end else begin
            infeed_enable <= 1'b0;
            teach_cnt     <= teach_cnt + 1'b1;
            teach_max     <= next_teach_max;
          end
        end
        ST_RUN: begin
          if (!run_s) begin
            state         <= ST_IDLE;
            infeed_enable <= 1'b0;
          end
        end
        default: begin
          state         <= ST_IDLE;
          infeed_enable <= 1'b0;
        end
      endcase
    end
  end

  assign teach_busy = (state == ST_TEACH);

  // ==========================================================
  // hardware compare qualification
  assign hw_compare_on = hw_compare_sel & sensor_is_ae & (fpga_rev >= `FLD_HW_MIN_REV);

  // ==========================================================
  // per-limit threshold and channel
  // a channel is only enabled in the run state, so teach produces no switchpoint
  wire chan_en = (state == ST_RUN);

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_lim
      wire [8:0]  s_raw = sens_tenths[gi*9 +: 9];
      wire [8:0]  s_cl  = (s_raw > `FLD_SENS_MAX) ? `FLD_SENS_MAX : s_raw;
      wire [8:0]  h_raw = hold_ms[gi*9 +: 9];
      wire [8:0]  h_cl  = (h_raw > `FLD_HOLD_MAX_MS) ? `FLD_HOLD_MAX_MS : h_raw;
      wire [15:0] man   = manual_thr[gi*16 +: 16];
      wire        sens0 = (s_cl == 9'h000);
      wire [4:0]  slot  = slot_of(gi[1:0], first_output_select, hw_compare_on, sensor_sel);
      // a slot past the last output behaves like an off limit
      wire        no_dest = (slot == 5'h00) || (slot > NUM_OUTS[4:0]);
      wire        off     = (sens0 && man == 16'h0000) || no_dest;
      reg  [15:0] eff_thr;
      wire [15:0] use_thr = sens0 ? man : eff_thr;

      // sens 0 keeps the manual value, so teach cannot move it
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          eff_thr <= 16'h0000;
        end else if (load_thr && !sens0) begin
          eff_thr <= calc_thr(load_pk, s_cl);
        end
      end

      // computed value shown while sensitivity is on, manual edits overridden
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          thr_shown[gi*16 +: 16] <= 16'h0000;
        end else begin
          thr_shown[gi*16 +: 16] <= use_thr;
        end
      end

      fld_limit_channel #(
        .MS_CYCLES (MS_CYCLES)
      ) u_chan (
        .clk         (clk),
        .rst         (rst),
        .enable      (chan_en),
        .sample_tick (sample_tick),
        .disabled    (off),
        .level       (level),
        .thr         (use_thr),
        .hold_ms     (h_cl),
        .active      (limit_active[gi])
      );
    end
  endgenerate

  // ==========================================================
  // output routing
  // each limit keeps its own slot whatever the others do; a shared slot is an OR
  reg [NUM_OUTS-1:0] next_switch_out;
  integer            k;
  integer            m;

  always @* begin
    next_switch_out = {NUM_OUTS{1'b0}};
    for (k = 0; k < NUM_OUTS; k = k + 1) begin
      for (m = 0; m < 4; m = m + 1) begin
        if (slot_of(m[1:0], first_output_select, hw_compare_on, sensor_sel) == k[4:0] + 5'h01) begin
          next_switch_out[k] = next_switch_out[k] | limit_active[m];
        end
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      switch_out <= {NUM_OUTS{1'b0}};
    end else if (!chan_en) begin
      switch_out <= {NUM_OUTS{1'b0}};
    end else begin
      switch_out <= next_switch_out;
    end
  end

endmodule // fld_limit_detector

`default_nettype wire

// *** sim/fld_limit_asserts.sv ***
// port-level properties of the four-level limit detector
// assumes only the detector's ports; bound to it at the foot of this file
`default_nettype none
// ==========================================================
// checker
module fld_limit_asserts #(
  parameter NUM_OUTS  = 8,  // outputs in the channel
  parameter MS_CYCLES = 10  // clocks per ms
) (
  input wire logic                clk,                 // system clock
  input wire logic                rst,                 // async reset
  input wire logic                sample_tick,         // sample pulse
  input wire logic [15:0]         meas_sample,         // measurement
  input wire logic [15:0]         signal_offset,       // offset
  input wire logic                abs_mode,            // absolute mode
  input wire logic                sensor_is_ae,        // ae sensor
  input wire logic                hw_compare_sel,      // hw compare setting
  input wire logic [7:0]          fpga_rev,            // logic revision
  input wire logic [3:0]          first_output_select, // first output
  input wire logic [35:0]         sens_tenths,         // sensitivities
  input wire logic [63:0]         manual_thr,          // manual thresholds
  input wire logic [35:0]         hold_ms,             // hold times
  input wire logic [NUM_OUTS-1:0] switch_out,          // outputs
  input wire logic [3:0]          limit_active,        // raw limit states
  input wire logic                infeed_enable,       // infeed release
  input wire logic                teach_busy,          // teach running
  input wire logic [15:0]         teach_peak_level,    // stored peak
  input wire logic                hw_compare_on        // hw mode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  int gap_age;
  // counts clocks the gap limit has been high, to judge its minimum hold
  always_ff @(posedge clk or posedge rst) begin
    if (rst) gap_age <= 0;
    else if (limit_active[0]) gap_age <= gap_age + 1;
    else gap_age <= 0;
  end
  a_teach_infeed: assert property (teach_busy |-> !infeed_enable)
    else $error("infeed released during teach");
  a_gap_strict: assert property (sample_tick && infeed_enable && sens_tenths[8:0] == 9'h000 && !sensor_is_ae
    && abs_mode && signal_offset == 16'h0000 && !meas_sample[15] && manual_thr[15:0] != 16'h0000
    && first_output_select != 4'h0 && first_output_select <= NUM_OUTS
    && meas_sample > manual_thr[15:0] |=> limit_active[0])
    else $error("gap not raised above threshold");
  a_tick_cause: assert property ($rose(limit_active[0]) |-> $past(sample_tick))
    else $error("gap rose without a sample");
  a_lim_off: assert property (sens_tenths[17:9] == 9'h000 && manual_thr[31:16] == 16'h0000
    && $past(manual_thr[31:16]) == 16'h0000 && $past(sens_tenths[17:9]) == 9'h000
    |-> !$rose(limit_active[1]))
    else $error("disabled limit asserted");
  a_hold_min: assert property ($fell(limit_active[0]) && $past(infeed_enable)
    |-> gap_age + 2 >= int'(hold_ms[8:0]) * MS_CYCLES)
    else $error("gap output dropped before its hold time");
  a_zero_latch: assert property (limit_active[2] && hold_ms[26:18] == 9'h000 && infeed_enable
    |=> limit_active[2] || !infeed_enable)
    else $error("zero-hold output released while running");
  a_peak_teach: assert property ($changed(teach_peak_level) |-> $fell(teach_busy) && infeed_enable)
    else $error("peak changed outside teach completion");
  a_abort_quiet: assert property ($fell(teach_busy) && !infeed_enable |-> ##1 (!infeed_enable && switch_out == '0))
    else $error("aborted teach produced output");
  a_hw_gate: assert property (hw_compare_on |-> hw_compare_sel && fpga_rev >= 8'h04)
    else $error("hw compare without setting or revision");
  a_sw_route: assert property (first_output_select == 4'h1 && $past(first_output_select) == 4'h1 && !hw_compare_on
    && !$past(hw_compare_on) && $past(limit_active[0]) && $past(infeed_enable) |-> switch_out[0])
    else $error("gap not routed to first output");
  a_fos_off: assert property (first_output_select == 4'h0 && $past(first_output_select) == 4'h0
    && !hw_compare_on && !$past(hw_compare_on) |-> switch_out == '0)
    else $error("software output with first output off");
endmodule // fld_limit_asserts
bind fld_limit_detector fld_limit_asserts #(.NUM_OUTS(NUM_OUTS), .MS_CYCLES(MS_CYCLES)) u_chk (
  .clk(clk), .rst(rst), .sample_tick(sample_tick), .meas_sample(meas_sample), .signal_offset(signal_offset),
  .abs_mode(abs_mode), .sensor_is_ae(sensor_is_ae), .hw_compare_sel(hw_compare_sel), .fpga_rev(fpga_rev),
  .first_output_select(first_output_select), .sens_tenths(sens_tenths), .manual_thr(manual_thr),
  .hold_ms(hold_ms), .switch_out(switch_out), .limit_active(limit_active), .infeed_enable(infeed_enable),
  .teach_busy(teach_busy), .teach_peak_level(teach_peak_level), .hw_compare_on(hw_compare_on));
`default_nettype wire

// *** sim/fld_mc_model.sv ***
// machine control model: drives cycle start/stop and teach pins
// assumes the bench asks for cycles; pins change just after a rising edge
`default_nettype none
// ==========================================================
// model
module fld_mc_model (
  input  wire logic clk,           // system clock
  input  wire logic run_req,       // bench asks for a running cycle
  input  wire logic teach_req,     // bench asks for a teach cycle
  output var  logic cycle_run_pin, // start/stop level
  output var  logic teach_pin      // teach level
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins are driven levels, never released, so no float handling is needed
  always @(posedge clk) begin
    cycle_run_pin <= run_req;
    teach_pin     <= teach_req;
  end
endmodule // fld_mc_model
`default_nettype wire

// *** sim/tb.sv ***
// self-checking bench for the four-level limit detector
// assumes short ms and teach counts; the control model drives the pins
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, run_req = 0, teach_req = 0, tick = 0, run_pin, teach_pin;
  logic abs_mode = 1, ae = 0, ssel = 0, hw_sel = 0, infeed, busy, hw_on;
  logic [15:0] meas = 0, offs = 0, peak;
  logic [7:0] rev = 8'h04, sw;
  logic [3:0] fos = 4'h1, act;
  logic [35:0] sens = 0, hold = {9'h001, 9'h000, 9'h000, 9'h002};
  logic [63:0] mthr = 64'h7000_3000_0000_1000, thr;
  int num_errors = 0, checks = 0, n;
  always #5 clk = ~clk;
  fld_mc_model mc (.clk(clk), .run_req(run_req), .teach_req(teach_req), .cycle_run_pin(run_pin),
    .teach_pin(teach_pin));
  fld_limit_detector #(.NUM_OUTS(8), .MS_CYCLES(10), .TEACH_CYCLES(200)) dut (.clk(clk), .rst(rst),
    .cycle_run_pin(run_pin), .teach_pin(teach_pin), .sample_tick(tick), .meas_sample(meas),
    .signal_offset(offs), .abs_mode(abs_mode), .sensor_is_ae(ae), .sensor_sel(ssel), .hw_compare_sel(hw_sel),
    .fpga_rev(rev), .first_output_select(fos), .sens_tenths(sens), .manual_thr(mthr), .hold_ms(hold),
    .switch_out(sw), .limit_active(act), .infeed_enable(infeed), .teach_busy(busy),
    .teach_peak_level(peak), .thr_shown(thr), .hw_compare_on(hw_on));
  // ==========================================================
  // helpers
  function automatic logic [15:0] thr_of(input logic [15:0] p, input logic [8:0] s);
    logic [31:0] t;
    t = {16'h0000, p} * (32'h0000000A + {23'h000000, s}) / 32'h0000000A;
    return (t > 32'h0000F850) ? 16'hF850 : t[15:0];
  endfunction
  // one sample; both limit_active and switch_out have landed on return
  task automatic smp(input logic [15:0] v);
    @(negedge clk) meas = v;
    tick = 1;
    @(negedge clk) tick = 0;
    @(negedge clk);
  endtask
  task automatic start(input logic t);
    @(negedge clk) teach_req = t;
    @(negedge clk) run_req = 1;
    repeat (7) @(negedge clk);
  endtask
  task automatic stop();
    @(negedge clk) run_req = 0;
    teach_req = 0;
    repeat (7) @(negedge clk);
  endtask
  task automatic complete_run();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    complete_run();
  end
  // ==========================================================
  // tests
  initial begin
    repeat (8) @(negedge clk);
    rst = 0;
    start(0);
    `CHK("infeed", 1'b1, infeed)
    `CHK("thr_shown", mthr, thr)
    smp(16'h1000);
    `CHK("equal level", 4'h0, act)
    smp(16'h1001);
    `CHK("gap out", 8'h01, sw)
    smp(16'h3001);
    `CHK("limits", 4'h5, act)
    `CHK("routing", 8'h05, sw)
    smp(16'h0000);
    `CHK("held", 4'h5, act)
    repeat (25) @(negedge clk);
    smp(16'h0000);
    `CHK("hold over", 4'h4, act)
    stop();
    `CHK("stop out", 8'h00, sw)
    `CHK("stop act", 4'h0, act)
    `CHK("stop infeed", 1'b0, infeed)
    fos = 4'h8;
    start(0);
    smp(16'h7FFF);
    `CHK("past end", 8'h80, sw)
    stop();
    fos = 4'h0;
    start(0);
    smp(16'h7FFF);
    `CHK("fos off", 8'h00, sw)
    ae = 1;
    hw_sel = 1;
    smp(16'h7FFF);
    `CHK("hw on", 1'b1, hw_on)
    `CHK("hw out", 8'h28, sw)
    ssel = 1;
    smp(16'h7FFF);
    `CHK("hw out s2", 8'h30, sw)
    stop();
    rev = 8'h03;
    @(negedge clk);
    `CHK("old rev", 1'b0, hw_on)
    fos = 4'h1;
    abs_mode = 0;
    offs = 16'h7000;
    start(0);
    smp(16'hE000);
    `CHK("ae abs", 4'h1, act)
    stop();
    {ae, abs_mode, offs} = {1'b0, 1'b1, 16'h0000};
    sens = {9'h18F, 9'h000, 9'h000, 9'h01E};
    start(1);
    `CHK("teach busy", 1'b1, busy)
    smp(16'h0800);
    smp(16'h1000);
    smp(16'h0400);
    `CHK("teach infeed", 1'b0, infeed)
    for (n = 0; n < 300 && busy === 1'b1; n++) @(negedge clk);
    @(negedge clk);
    `CHK("infeed", 1'b1, infeed)
    `CHK("peak", 16'h1000, peak)
    `CHK("thr gap", thr_of(16'h1000, 9'h01E), thr[15:0])
    `CHK("thr lim2", 16'h3000, thr[47:32])
    `CHK("thr clamp", thr_of(16'h1000, 9'h18F), thr[63:48])
    smp(16'h3000);
    `CHK("manual ignored", 1'b0, act[0])
    smp(16'h4001);
    `CHK("computed", 1'b1, act[0])
    stop();
    sens[8:0] = 9'h001;
    start(0);
    `CHK("recalc", thr_of(16'h1000, 9'h001), thr[15:0])
    stop();
    start(1);
    smp(16'h7FFF);
    stop();
    `CHK("abort peak", 16'h1000, peak)
    `CHK("abort infeed", 1'b0, infeed)
    complete_run();
  end
endmodule // tb
`default_nettype wire
